// file: verilog/pfc_pkg.sv
// Constants, types and helper functions for the profiling event counters
package pfc_pkg;

  localparam int NUM_EV = 6;
  localparam int FW = 26;
  localparam int AW = 8;
  localparam int EV_IDX_W = 3;

  // Arbitrary implementation figures
  localparam logic [FW-1:0] MIN_INTERVAL = 26'h000_0100;
  localparam logic [31:0] EVENT_SIZE = 32'h0000_0020;
  localparam logic [31:0] FLAGS_AVAIL = 32'hE000_007E;

  // Flags word
  localparam int FLG_EV_LO = 1;
  localparam int FLG_CONTINUOUS_MODE_SELECT = 29;
  localparam int FLG_TS = 30;
  localparam int FLG_INT = 31;

  // Command word bits
  localparam int CMD_LOAD = 0;
  localparam int CMD_STORE = 1;

  // Register map (byte addresses)
  localparam logic [AW-1:0] REG_FLAGS = 8'h00;
  localparam logic [AW-1:0] REG_SIZE = 8'h04;
  localparam logic [AW-1:0] REG_HEAD = 8'h08;
  localparam logic [AW-1:0] REG_TAIL = 8'h0C;
  localparam logic [AW-1:0] REG_THRESH = 8'h10;
  localparam logic [AW-1:0] REG_DROP_LO = 8'h14;
  localparam logic [AW-1:0] REG_DROP_HI = 8'h18;
  localparam logic [AW-1:0] REG_CMD = 8'h1C;
  localparam logic [AW-1:0] REG_STATUS = 8'h20;
  // Event pairs: base + 8*index, interval then counter
  localparam logic [1:0] EV_AREA_TAG = 2'h1;

  typedef struct packed {
    logic [EV_IDX_W-1:0] event_id;
    logic [63:0] timestamp;
    logic [31:0] offset;
  } pfc_record_t;

  function automatic logic ev_hit(input logic [AW-1:0] a);
    return (a[7:6] == EV_AREA_TAG) && (int'(a[5:3]) < NUM_EV) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [EV_IDX_W-1:0] ev_idx(input logic [AW-1:0] a);
    return a[5:3];
  endfunction

  function automatic logic ev_is_cnt(input logic [AW-1:0] a);
    return a[2];
  endfunction

  // Negative becomes zero
  function automatic logic [FW-1:0] clamp_zero(input logic [FW-1:0] v);
    return v[FW-1] ? '0 : v;
  endfunction

  // Negative or short becomes the minimum
  function automatic logic [FW-1:0] clamp_min(input logic [FW-1:0] v);
    return (v[FW-1] || v < MIN_INTERVAL) ? MIN_INTERVAL : v;
  endfunction

endpackage

// file: verilog/pfc_evcnt.sv
// One event down-counter with reload on expiry
`timescale 1ns/10ps
module pfc_evcnt
  import pfc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic load,
  input wire logic [FW-1:0] load_val,
  input wire logic [FW-1:0] interval,
  input wire logic en,
  input wire logic ev,
  output logic [FW-1:0] count_reg,
  output logic expire_reg
);

  always_ff @(posedge clock) begin
    if (srst) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= load_val;
    end else if (en && ev) begin
      if (count_reg == '0) begin
        count_reg <= interval;
      end else begin
        count_reg <= count_reg - 26'h000_0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      expire_reg <= 1'b0;
    end else begin
      expire_reg <= !load && en && ev && (count_reg == '0);
    end
  end

  a_expire_cause: assert property (@(posedge clock) disable iff (srst)
    expire_reg |-> $past(count_reg) == '0 && $past(ev) && $past(en))
    else $error("counter expired without a zero count and event");

  a_load_value: assert property (@(posedge clock) disable iff (srst)
    load |=> count_reg == $past(load_val))
    else $error("counter did not take its load value");

  a_reload_interval: assert property (@(posedge clock) disable iff (srst)
    expire_reg |-> count_reg == $past(interval))
    else $error("counter did not reload from interval on expiry");

endmodule // pfc_evcnt

// file: verilog/pfc_core.sv
// Profiling unit: control block image, event counters and ring record writer
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module pfc_core
  import pfc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic [NUM_EV-1:0] ev_in,
  input wire logic [63:0] tsc,
  output logic rec_valid,
  output pfc_record_t rec,
  output logic thresh_irq,
  output logic [NUM_EV-1:0] ev_active
);

  logic [31:0] flags_reg;
  logic [31:0] eff_flags_reg;
  logic [31:0] size_reg;
  logic [31:0] head_reg;
  logic [31:0] tail_reg;
  logic [31:0] thr_reg;
  logic [63:0] drop_reg;
  logic [FW-1:0] intv_reg [NUM_EV];
  logic [FW-1:0] cnt_reg [NUM_EV];
  logic [FW-1:0] live_cnt [NUM_EV];
  logic [NUM_EV-1:0] expire;
  logic [NUM_EV-1:0] pend_reg;
  logic [NUM_EV-1:0] pick;
  logic [EV_IDX_W-1:0] pick_idx;
  logic [31:0] head_next;
  logic [31:0] used_next;
  logic [31:0] thr_eff;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  logic rec_valid_reg;
  pfc_record_t rec_reg;
  logic irq_reg;
  logic [NUM_EV-1:0] active_reg;
  logic do_load;
  logic do_store;
  logic writing;
  logic full_hit;

  assign do_load = wr_en && (addr == REG_CMD) && wdata[CMD_LOAD];
  assign do_store = wr_en && (addr == REG_CMD) && wdata[CMD_STORE];
  assign writing = |pend_reg;

  // Interval clamp that applies to an event slot
  function automatic logic [FW-1:0] clamp_intv(input int i, input logic [FW-1:0] v);
    return (i == 0) ? clamp_zero(v) : clamp_min(v);
  endfunction

  // Ring offset after one record, wrapping at the buffer end
  function automatic logic [31:0] ring_step(input logic [31:0] h, input logic [31:0] sz);
    logic [31:0] n;
    n = h + EVENT_SIZE;
    return (n >= sz) ? '0 : n;
  endfunction

  // Counters
  for (genvar g = 0; g < NUM_EV; g++) begin : g_ev
    pfc_evcnt u_cnt (
      .clock(clock),
      .srst(srst),
      .load(do_load),
      .load_val(clamp_zero(cnt_reg[g])),
      .interval(intv_reg[g]),
      .en(active_reg[g]),
      .ev(ev_in[g]),
      .count_reg(live_cnt[g]),
      .expire_reg(expire[g])
    );
  end

  // Flags: loaded flags are masked by what is available
  always_ff @(posedge clock) begin
    if (srst) begin
      flags_reg <= '0;
      eff_flags_reg <= '0;
    end else if (do_load) begin
      flags_reg <= flags_reg & FLAGS_AVAIL;
      eff_flags_reg <= flags_reg & FLAGS_AVAIL;
    end else if (wr_en && addr == REG_FLAGS) begin
      flags_reg <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      active_reg <= '0;
    end else if (do_load) begin
      active_reg <= flags_reg[FLG_EV_LO +: NUM_EV] & FLAGS_AVAIL[FLG_EV_LO +: NUM_EV];
    end
  end

  // Interval and counter image with write-back on load and store
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < NUM_EV; i++) begin
        intv_reg[i] <= '0;
        cnt_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_EV; i++) begin
        if (do_load) begin
          intv_reg[i] <= clamp_intv(i, intv_reg[i]);
          cnt_reg[i] <= clamp_zero(cnt_reg[i]);
        end else if (do_store) begin
          cnt_reg[i] <= live_cnt[i];
        end else if (wr_en && ev_hit(addr) && int'(ev_idx(addr)) == i) begin
          if (ev_is_cnt(addr)) begin
            cnt_reg[i] <= wdata[FW-1:0];
          end else begin
            intv_reg[i] <= wdata[FW-1:0];
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      size_reg <= '0;
      tail_reg <= '0;
      thr_reg <= '0;
    end else if (wr_en) begin
      if (addr == REG_SIZE) begin
        size_reg <= wdata;
      end
      if (addr == REG_TAIL) begin
        tail_reg <= wdata;
      end
      if (addr == REG_THRESH) begin
        thr_reg <= wdata;
      end
    end
  end

  // Pending records, lowest event first; a new expiry wins over the clear of a picked record, a load clears all
  always_comb begin
    pick = '0;
    pick_idx = '0;
    for (int i = NUM_EV - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        pick = '0;
        pick[i] = 1'b1;
        pick_idx = EV_IDX_W'(i);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst || do_load) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= (pend_reg & ~pick) | expire;
    end
  end

  // Ring head and overflow handling
  assign head_next = ring_step(head_reg, size_reg);
  assign full_hit = (head_next == tail_reg) && !eff_flags_reg[FLG_CONTINUOUS_MODE_SELECT];
  assign thr_eff = thr_reg & ~(EVENT_SIZE - 32'h0000_0001);
  assign used_next = (head_next >= tail_reg) ? head_next - tail_reg
                                             : head_next + size_reg - tail_reg;

  // Head advance takes priority over a software write in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      head_reg <= '0;
    end else if (writing && !full_hit) begin
      head_reg <= head_next;
    end else if (wr_en && addr == REG_HEAD) begin
      head_reg <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      drop_reg <= '0;
    end else if (writing && full_hit) begin
      drop_reg <= drop_reg + 64'h0000_0000_0000_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rec_valid_reg <= 1'b0;
      rec_reg <= '0;
    end else begin
      rec_valid_reg <= writing;
      if (writing) begin
        rec_reg.event_id <= pick_idx + EV_IDX_W'(1);
        rec_reg.timestamp <= eff_flags_reg[FLG_TS] ? tsc : '0;
        rec_reg.offset <= head_reg;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= writing && !full_hit && eff_flags_reg[FLG_INT]
                 && (used_next >= thr_eff);
    end
  end

  // Register read port
  always_comb begin
    rdata_next = '0;
    if (ev_hit(addr)) begin
      rdata_next = {{(32 - FW){1'b0}},
                    ev_is_cnt(addr) ? cnt_reg[ev_idx(addr)] : intv_reg[ev_idx(addr)]};
    end else begin
      unique case (addr)
        REG_FLAGS: rdata_next = flags_reg;
        REG_SIZE: rdata_next = size_reg;
        REG_HEAD: rdata_next = head_reg;
        REG_TAIL: rdata_next = tail_reg;
        REG_THRESH: rdata_next = thr_reg;
        REG_DROP_LO: rdata_next = drop_reg[31:0];
        REG_DROP_HI: rdata_next = drop_reg[63:32];
        REG_STATUS: rdata_next = {{(32 - NUM_EV){1'b0}}, active_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rd_en ? rdata_next : '0;
    end
  end

  assign rdata = rdata_reg;
  assign rec_valid = rec_valid_reg;
  assign rec = rec_reg;
  assign thresh_irq = irq_reg;
  assign ev_active = active_reg;

  a_flags_mask: assert property (@(posedge clock) disable iff (srst)
    do_load |=> (flags_reg & ~FLAGS_AVAIL) == '0 && eff_flags_reg == flags_reg)
    else $error("flags not masked to available features on load");

  a_sample_clamp: assert property (@(posedge clock) disable iff (srst)
    do_load && intv_reg[0][FW-1] |=> intv_reg[0] == '0)
    else $error("negative sample interval not replaced by zero");

  a_sample_keep: assert property (@(posedge clock) disable iff (srst)
    do_load && !intv_reg[0][FW-1] |=> intv_reg[0] == $past(intv_reg[0]))
    else $error("short sample interval altered on load");

  a_retired_clamp: assert property (@(posedge clock) disable iff (srst)
    do_load && (intv_reg[1][FW-1] || intv_reg[1] < MIN_INTERVAL)
    |=> intv_reg[1] == MIN_INTERVAL)
    else $error("short retired-instruction interval not raised to minimum");

  a_other_clamp: assert property (@(posedge clock) disable iff (srst)
    do_load && (intv_reg[NUM_EV-1][FW-1] || intv_reg[NUM_EV-1] < MIN_INTERVAL)
    |=> intv_reg[NUM_EV-1] == MIN_INTERVAL)
    else $error("short interval of the last event not raised to minimum");

  a_count_clamp: assert property (@(posedge clock) disable iff (srst)
    do_load && cnt_reg[1][FW-1] |=> cnt_reg[1] == '0)
    else $error("negative counter not replaced by zero on load");

  a_store_capture: assert property (@(posedge clock) disable iff (srst)
    do_store && !do_load |=> cnt_reg[1] == $past(live_cnt[1]))
    else $error("store did not capture the live count");

  a_active_mask: assert property (@(posedge clock) disable iff (srst)
    do_load |=> ev_active == ($past(flags_reg[FLG_EV_LO +: NUM_EV])
                              & FLAGS_AVAIL[FLG_EV_LO +: NUM_EV]))
    else $error("enabled events do not follow the loaded flags");

  a_continuous_mode_select_select: assert property (@(posedge clock) disable iff (srst)
    do_load |=> eff_flags_reg[FLG_CONTINUOUS_MODE_SELECT]
                == ($past(flags_reg[FLG_CONTINUOUS_MODE_SELECT]) && FLAGS_AVAIL[FLG_CONTINUOUS_MODE_SELECT]))
    else $error("continuous mode not taken from selection and availability");

  a_drop_count: assert property (@(posedge clock) disable iff (srst)
    writing && full_hit |=> drop_reg == $past(drop_reg) + 64'h0000_0000_0000_0001
                            && head_reg == $past(head_reg))
    else $error("full ring did not hold head and count a dropped record");

  a_head_advance: assert property (@(posedge clock) disable iff (srst)
    writing && !full_hit |=> head_reg == $past(head_next))
    else $error("head did not advance after a record");

  a_continuous_mode_select_advance: assert property (@(posedge clock) disable iff (srst)
    writing && eff_flags_reg[FLG_CONTINUOUS_MODE_SELECT] |=> head_reg == $past(head_next))
    else $error("continuous mode failed to advance head");

  a_continuous_mode_select_nodrop: assert property (@(posedge clock) disable iff (srst)
    writing && eff_flags_reg[FLG_CONTINUOUS_MODE_SELECT] |=> drop_reg == $past(drop_reg))
    else $error("continuous mode counted a dropped record");

  a_record_offset: assert property (@(posedge clock) disable iff (srst)
    writing |=> rec_valid && rec.offset == $past(head_reg))
    else $error("record not written at the head offset");

  a_pick_lowest: assert property (@(posedge clock) disable iff (srst)
    rec_valid && rec.event_id != EV_IDX_W'(1) |-> !$past(pend_reg[0]))
    else $error("later event recorded ahead of a pending sample event");

  a_pend_set: assert property (@(posedge clock) disable iff (srst)
    expire != '0 && !do_load |=> pend_reg != '0)
    else $error("expiry lost before its record");

  a_irq_enable: assert property (@(posedge clock) disable iff (srst)
    thresh_irq |-> $past(eff_flags_reg[FLG_INT]) && $past(used_next) >= $past(thr_eff))
    else $error("threshold interrupt without enable or fill level");

  a_irq_record: assert property (@(posedge clock) disable iff (srst)
    thresh_irq |-> rec_valid)
    else $error("threshold interrupt without a stored record");

  a_irq_zero: assert property (@(posedge clock) disable iff (srst)
    writing && !full_hit && eff_flags_reg[FLG_INT] && thr_reg == '0
    |=> thresh_irq)
    else $error("zero threshold did not interrupt on a head advance");

  a_timestamp_zero: assert property (@(posedge clock) disable iff (srst)
    rec_valid && !$past(eff_flags_reg[FLG_TS]) |-> rec.timestamp == '0)
    else $error("timestamp stored while not selected");

  a_ts_stored: assert property (@(posedge clock) disable iff (srst)
    rec_valid && $past(eff_flags_reg[FLG_TS]) |-> rec.timestamp == $past(tsc))
    else $error("selected timestamp not stored in the record");

  a_expiry_to_record: assert property (@(posedge clock) disable iff (srst)
    expire[0] && !do_load |-> ##[1:6] rec_valid)
    else $error("sample expiry produced no record");

  c_record: cover property (@(posedge clock) disable iff (srst) rec_valid);
  c_drop: cover property (@(posedge clock) disable iff (srst) writing && full_hit);
  c_irq: cover property (@(posedge clock) disable iff (srst) thresh_irq);
  c_two_pending: cover property (@(posedge clock) disable iff (srst) $countones(pend_reg) > 1);
  c_continuous_mode_select_wrap: cover property (@(posedge clock) disable iff (srst)
    writing && eff_flags_reg[FLG_CONTINUOUS_MODE_SELECT] && head_next == tail_reg);

endmodule // pfc_core

// file: tb/pfc_ring_model.sv
// Ring buffer partner model: counts every record on rec_valid, dropped ones included, and fill interrupts
`timescale 1ns/10ps
module pfc_ring_model
  import pfc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic rec_valid,
  input wire pfc_record_t rec,
  input wire logic thresh_irq,
  output int n_rec,
  output int n_irq,
  output pfc_record_t last
);
  // Software stops profiling before it drains the ring, so no tail updates here
  always_ff @(posedge clock) begin
    if (srst) begin
      n_rec <= 0;
      n_irq <= 0;
      last <= '0;
    end else begin
      if (rec_valid === 1'b1) begin
        n_rec <= n_rec + 1;
        last <= rec;
      end
      if (thresh_irq === 1'b1) begin
        n_irq <= n_irq + 1;
      end
    end
  end
endmodule // pfc_ring_model

// file: tb/test_profiling_event_counters.sv
// Directed testbench for the profiling event counter core
`timescale 1ns/10ps
module test_profiling_event_counters;
  import pfc_pkg::*;
  logic clock;
  logic srst;
  logic [AW-1:0] addr;
  logic [31:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata;
  logic [NUM_EV-1:0] ev_in;
  logic [63:0] tsc;
  logic rec_valid;
  pfc_record_t rec;
  logic thresh_irq;
  logic [NUM_EV-1:0] ev_active;
  int n_rec;
  int n_irq;
  pfc_record_t last;
  int fail_count;
  int tests_run;

  pfc_core i_pfc_core (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .ev_in(ev_in), .tsc(tsc), .rec_valid(rec_valid), .rec(rec),
    .thresh_irq(thresh_irq), .ev_active(ev_active));
  pfc_ring_model i_pfc_ring_model (.clock(clock), .srst(srst), .rec_valid(rec_valid),
    .rec(rec), .thresh_irq(thresh_irq), .n_rec(n_rec), .n_irq(n_irq), .last(last));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    check(64'(rdata), 64'(e));
  endtask

  // Holds one event line high for n cycles, then lets records drain
  task automatic ev(input int i, input int n);
    @(posedge clock);
    ev_in <= NUM_EV'(1 << i);
    repeat (n) @(posedge clock);
    ev_in <= '0;
    repeat (4) @(posedge clock);
  endtask

  task automatic setup(input logic [31:0] f, input logic [31:0] i0, input logic [31:0] c0,
                       input logic [31:0] i1, input logic [31:0] c1);
    wr(REG_FLAGS, f);
    wr(8'h40, i0);
    wr(8'h44, c0);
    wr(8'h48, i1);
    wr(8'h4C, c1);
    wr(REG_CMD, 32'h0000_0001);
    wr(REG_HEAD, 32'h0000_0000);
    wr(REG_TAIL, 32'h0000_0000);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  initial begin
    fail_count = 0;
    tests_run = 0;
    srst = 1'b1;
    addr = '0;
    wdata = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ev_in = '0;
    tsc = 64'h1234_5678_9ABC_DEF0;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    wr(8'h70, 32'hFFFF_FFFF);
    wr(8'h24, 32'hFFFF_FFFF);
    rd(REG_FLAGS, 32'h0000_0000);
    rd(REG_STATUS, 32'h0000_0000);
    rd(8'h70, 32'h0000_0000);
    rd(8'h24, 32'h0000_0000);
    $display("test reset done");
    wr(8'h50, 32'h03FF_FFFF);
    wr(8'h58, 32'h0000_0200);
    setup(32'hFFFF_FFFF, 32'h03FF_FFFF, 32'h03FF_FFFF, 32'h0000_0010, 32'h03FF_FFFF);
    rd(REG_FLAGS, 32'hE000_007E);
    rd(8'h40, 32'h0000_0000);
    rd(8'h44, 32'h0000_0000);
    rd(8'h48, 32'h0000_0100);
    rd(8'h4C, 32'h0000_0000);
    rd(8'h50, 32'h0000_0100);
    rd(8'h58, 32'h0000_0200);
    rd(REG_STATUS, 32'h0000_003F);
    check(64'(ev_active), 64'h0000_0000_0000_003F);
    $display("test load clamping done");
    wr(REG_SIZE, 32'h0000_0100);
    wr(REG_THRESH, 32'h0000_0040);
    setup(32'hC000_0002, 32'h0000_0005, 32'h0000_0002, 32'h0000_0100, 32'h0000_0000);
    rd(8'h40, 32'h0000_0005);
    ev(0, 2);
    check(64'(n_rec), 64'h0000_0000_0000_0000);
    ev(0, 1);
    check(64'(n_rec), 64'h0000_0000_0000_0001);
    check(64'(last.event_id), 64'h0000_0000_0000_0001);
    check(last.timestamp, tsc);
    check(64'(n_irq), 64'h0000_0000_0000_0000);
    ev(0, 6);
    check(64'(n_rec), 64'h0000_0000_0000_0002);
    check(64'(last.offset), 64'h0000_0000_0000_0020);
    check(64'(n_irq), 64'h0000_0000_0000_0001);
    rd(REG_HEAD, 32'h0000_0040);
    $display("test sample event done");
    setup(32'h0000_0004, 32'h0000_0000, 32'h0000_0000, 32'h0000_0100, 32'h0000_0005);
    ev(0, 3);
    check(64'(n_rec), 64'h0000_0000_0000_0002);
    ev(1, 2);
    wr(REG_CMD, 32'h0000_0002);
    rd(8'h4C, 32'h0000_0003);
    ev(1, 4);
    check(64'(n_rec), 64'h0000_0000_0000_0003);
    check(64'(last.event_id), 64'h0000_0000_0000_0002);
    check(last.timestamp, 64'h0000_0000_0000_0000);
    ev(1, 256);
    check(64'(n_rec), 64'h0000_0000_0000_0003);
    ev(1, 1);
    check(64'(n_rec), 64'h0000_0000_0000_0004);
    check(64'(n_irq), 64'h0000_0000_0000_0001);
    $display("test retired event done");
    wr(REG_SIZE, 32'h0000_0040);
    setup(32'h0000_0002, 32'h0000_0000, 32'h0000_0000, 32'h0000_0100, 32'h0000_0000);
    ev(0, 3);
    check(64'(n_rec), 64'h0000_0000_0000_0007);
    check(64'(last.offset), 64'h0000_0000_0000_0020);
    rd(REG_HEAD, 32'h0000_0020);
    rd(REG_DROP_LO, 32'h0000_0002);
    rd(REG_DROP_HI, 32'h0000_0000);
    $display("test sync overflow done");
    setup(32'h2000_0002, 32'h0000_0000, 32'h0000_0000, 32'h0000_0100, 32'h0000_0000);
    rd(REG_FLAGS, 32'h2000_0002);
    ev(0, 3);
    check(64'(n_rec), 64'h0000_0000_0000_000A);
    check(64'(last.offset), 64'h0000_0000_0000_0000);
    rd(REG_HEAD, 32'h0000_0020);
    rd(REG_DROP_LO, 32'h0000_0002);
    $display("test continuous mode done");
    wr(REG_THRESH, 32'h0000_0000);
    wr(8'h6C, 32'h0000_0000);
    setup(32'h8000_0042, 32'h0000_0000, 32'h0000_0000, 32'h0000_0100, 32'h0000_0000);
    check(64'(ev_active), 64'h0000_0000_0000_0021);
    @(posedge clock);
    ev_in <= 6'h21;
    @(posedge clock);
    ev_in <= '0;
    // Two records queue up; wait until both have reached the model
    repeat (6) @(posedge clock);
    check(64'(n_rec), 64'h0000_0000_0000_000C);
    check(64'(last.event_id), 64'h0000_0000_0000_0006);
    check(64'(last.offset), 64'h0000_0000_0000_0020);
    check(64'(n_irq), 64'h0000_0000_0000_0002);
    rd(REG_DROP_LO, 32'h0000_0003);
    $display("test event priority done");
    close_out();
  end
endmodule // test_profiling_event_counters
